/* File: design/dtt_pkg.sv */
// Package for the DRAM thermal throttle block: types, weights, reset values.
// Assumes a single host clock domain; no software register map.
package dtt_pkg;
  localparam int ROW_W = 3;
  localparam int CNT_W = 24;
  localparam int WIN_W = 20;
  // Default window and threshold, in host clock cycles and weighted units
  localparam logic [WIN_W-1:0] WIN_CYC_DFLT = 20'h0ffff;
  localparam logic [CNT_W-1:0] THR_DFLT = 24'h00ffff;
  // Default weights per cycle type (hit cheapest, miss dearest)
  localparam logic [3:0] W_HIT_DFLT = 4'h1;
  localparam logic [3:0] W_EMPTY_DFLT = 4'h2;
  localparam logic [3:0] W_MISS_DFLT = 4'h3;
  // Throttle duty: this many slots blocked out of one more than this when throttling (every slot at 0)
  localparam logic [3:0] DUTY_DFLT = 4'h2;
  localparam logic [3:0] DUTY_RST = 4'h0;
  localparam logic [CNT_W-1:0] CNT_RST = 24'h000000;
  localparam logic [WIN_W-1:0] WIN_RST = 20'h00000;

  typedef enum logic [1:0] {
    DTT_HIT = 2'h0,
    DTT_EMPTY = 2'h1,
    DTT_MISS = 2'h3
  } dtt_cyc_t;

  // One hexword transfer report from the memory scheduler
  typedef struct packed {
    logic valid;
    logic [ROW_W-1:0] row;
    dtt_cyc_t cyc;
  } dtt_xfer_t;

  // Throttle settings, held static by the surrounding configuration
  typedef struct packed {
    logic [CNT_W-1:0] threshold;
    logic [WIN_W-1:0] window;
    logic [3:0] w_hit;
    logic [3:0] w_empty;
    logic [3:0] w_miss;
    logic [3:0] duty;
    logic ot_irq_en;
    logic ot_rd_thr_en;
  } dtt_cfg_t;

  typedef enum logic [1:0] {
    DTT_ST_IDLE = 2'b00,
    DTT_ST_THROTTLE = 2'b01,
    DTT_ST_HOLD = 2'b11
  } dtt_state_t;
endpackage

/* File: design/dtt_sync.sv */
// Two-flop synchroniser for the external over-temperature level.
// Assumes the input is asynchronous; reset value is the idle (high) level.
`timescale 1ns/1ps
module dtt_sync (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_async,
  output logic o_sync
);
  logic meta_q;
  logic sync_q;

  // First stage feeds only the second
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule

/* File: design/dtt_throttle.sv */
// DRAM thermal throttle: weighted per-row transfer tracking and sensor input.
// Assumes i_clk is the host clock and the scheduler honours the throttle outputs.
`timescale 1ns/1ps
module dtt_throttle #(
  parameter int ROWS = 8,
  parameter int CNT_W = dtt_pkg::CNT_W,
  parameter int WIN_W = dtt_pkg::WIN_W
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire dtt_pkg::dtt_xfer_t i_xfer,
  input wire dtt_pkg::dtt_cfg_t i_cfg,
  input wire logic i_over_temp_in_n,
  output logic o_rd_throttle,
  output logic o_wr_throttle,
  output logic o_ot_irq,
  output logic o_hw_active,
  output logic [ROWS-1:0] o_row_hot
);
  localparam int ROW_W = dtt_pkg::ROW_W;

  // Row field and struct widths are fixed by the package
  if (ROWS < 1 || ROWS > (1 << ROW_W)) begin : g_bad_rows
    $error("dtt_throttle: ROWS must fit the row field");
  end
  if (CNT_W != dtt_pkg::CNT_W || WIN_W != dtt_pkg::WIN_W) begin : g_bad_width
    $error("dtt_throttle: counter widths must match the package");
  end

  logic ot_sync;
  logic [WIN_W-1:0] win_q;
  logic [WIN_W-1:0] win_d;
  logic [CNT_W-1:0] cnt_q [ROWS];
  logic [ROWS-1:0] hot_q;
  logic [ROWS-1:0] hot_d;
  logic [ROWS-1:0] over;
  dtt_pkg::dtt_state_t st_q;
  dtt_pkg::dtt_state_t st_d;
  logic [3:0] duty_cnt_q;
  logic [3:0] duty_cnt_d;
  logic rd_thr_q;
  logic wr_thr_q;
  logic irq_q;
  logic [3:0] weight;
  logic win_end;
  logic any_over;
  logic slot_block;
  logic ot_active;
  logic is_hit;
  logic is_empty;
  logic hw_active_q;
  logic hw_active_d;
  logic rd_thr_d;
  logic wr_thr_d;
  logic irq_d;
  logic ot_rd_req;

  dtt_sync u_sync (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_async(i_over_temp_in_n),
    .o_sync(ot_sync)
  );

  assign ot_active = ~ot_sync;

  assign is_hit = (i_xfer.cyc == dtt_pkg::DTT_HIT);
  assign is_empty = (i_xfer.cyc == dtt_pkg::DTT_EMPTY);
  // Codes outside the enum count as the dearest cycle
  assign weight = is_hit ? i_cfg.w_hit : (is_empty ? i_cfg.w_empty : i_cfg.w_miss);

  assign win_end = (win_q >= i_cfg.window);
  assign win_d = win_end ? dtt_pkg::WIN_RST : win_q + 1'b1;

  genvar g;
  generate
    for (g = 0; g < ROWS; g++) begin : g_row
      logic hit_row;
      logic [CNT_W:0] sum;
      logic [CNT_W-1:0] cnt_d;
      assign hit_row = i_xfer.valid && (i_xfer.row == ROW_W'(g));
      assign sum = {1'b0, cnt_q[g]} + {{(CNT_W - 4 + 1){1'b0}}, (hit_row ? weight : 4'h0)};
      // Saturate so a long window cannot wrap back under threshold
      assign cnt_d = win_end ? dtt_pkg::CNT_RST :
                     (sum[CNT_W] ? {CNT_W{1'b1}} : sum[CNT_W-1:0]);
      assign over[g] = (sum[CNT_W] || sum[CNT_W-1:0] > i_cfg.threshold);
      assign hot_d[g] = win_end ? 1'b0 : (hot_q[g] | over[g]);
      always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          cnt_q[g] <= dtt_pkg::CNT_RST;
        end else begin
          cnt_q[g] <= cnt_d;
        end
      end
    end
  endgenerate

  assign any_over = |(hot_q | over);

  // Throttle held through the window after the crossing
  always_comb begin
    st_d = st_q;
    case (st_q)
      dtt_pkg::DTT_ST_IDLE: begin
        if (any_over) begin
          st_d = dtt_pkg::DTT_ST_THROTTLE;
        end
      end
      dtt_pkg::DTT_ST_THROTTLE: begin
        if (win_end) begin
          st_d = dtt_pkg::DTT_ST_HOLD;
        end
      end
      dtt_pkg::DTT_ST_HOLD: begin
        // One more window throttled gives the parts time to cool
        if (win_end) begin
          st_d = any_over ? dtt_pkg::DTT_ST_THROTTLE : dtt_pkg::DTT_ST_IDLE;
        end
      end
      default: begin
        st_d = dtt_pkg::DTT_ST_IDLE;
      end
    endcase
  end

  // Duty counter: one free slot per duty+1 cycles, none free at duty 0
  assign duty_cnt_d = (duty_cnt_q >= i_cfg.duty) ? dtt_pkg::DUTY_RST : duty_cnt_q + 1'b1;
  assign slot_block = (duty_cnt_q != dtt_pkg::DUTY_RST) || (i_cfg.duty == dtt_pkg::DUTY_RST);

  // Window runs free, so the first window starts at reset release
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      win_q <= dtt_pkg::WIN_RST;
    end else begin
      win_q <= win_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      hot_q <= '0;
    end else begin
      hot_q <= hot_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= dtt_pkg::DTT_ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      duty_cnt_q <= dtt_pkg::DUTY_RST;
    end else begin
      duty_cnt_q <= duty_cnt_d;
    end
  end

  assign hw_active_d = (st_d != dtt_pkg::DTT_ST_IDLE);
  assign ot_rd_req = ot_active && i_cfg.ot_rd_thr_en;
  assign rd_thr_d = slot_block && (hw_active_d || ot_rd_req);
  assign wr_thr_d = slot_block && hw_active_d;
  assign irq_d = ot_active && i_cfg.ot_irq_en;

  // Outputs straight from flops, so the scheduler never sees a glitch
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      hw_active_q <= 1'b0;
    end else begin
      hw_active_q <= hw_active_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rd_thr_q <= 1'b0;
    end else begin
      rd_thr_q <= rd_thr_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_thr_q <= 1'b0;
    end else begin
      wr_thr_q <= wr_thr_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  assign o_rd_throttle = rd_thr_q;
  assign o_wr_throttle = wr_thr_q;
  assign o_ot_irq = irq_q;
  assign o_hw_active = hw_active_q;
  assign o_row_hot = hot_q;
endmodule

/* File: tb/dtt_sensor_model.sv */
// Sensor with an open-drain alarm and a board pull-up.
// Assumes the bench drives i_hot.
`timescale 1ns/1ps
module dtt_sensor_model (
  input wire logic i_hot,
  output wire logic o_alert_n
);
  assign o_alert_n = i_hot ? 1'b0 : 1'bz;
  pullup (o_alert_n);
endmodule

/* File: tb/dtt_throttle_monitor.sv */
// Port checker for the throttle block.
// Assumes i_cfg is static while checked.
`timescale 1ns/1ps
module dtt_throttle_monitor #(parameter int ROWS = 8) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire dtt_pkg::dtt_xfer_t i_xfer,
  input wire dtt_pkg::dtt_cfg_t i_cfg,
  input wire logic i_over_temp_in_n,
  input wire logic o_rd_throttle,
  input wire logic o_wr_throttle,
  input wire logic o_ot_irq,
  input wire logic o_hw_active,
  input wire logic [ROWS-1:0] o_row_hot
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_hot3; !i_over_temp_in_n [*3]; endsequence
  sequence s_cool3; i_over_temp_in_n [*3]; endsequence
  a_irq_follow: assert property (i_cfg.ot_irq_en ##0 s_hot3 |=> o_ot_irq)
    else $error("irq missing");
  a_irq_drop: assert property (s_cool3 |=> !o_ot_irq)
    else $error("irq stuck");
  a_irq_gate: assert property (!i_cfg.ot_irq_en |-> !o_ot_irq)
    else $error("irq not gated");
  a_ot_rd: assert property (i_cfg.ot_rd_thr_en && i_cfg.duty == 4'h0 ##0 s_hot3 |=> o_rd_throttle)
    else $error("read throttle missing");
  a_hw_cross: assert property ($rose(|o_row_hot) |-> o_hw_active)
    else $error("hot row without throttle");
  a_wr_idle: assert property (!o_hw_active [*2] |-> !o_wr_throttle)
    else $error("write throttle while idle");
  a_wr_duty0: assert property (i_cfg.duty == 4'h0 ##0 o_hw_active [*2] |-> o_wr_throttle)
    else $error("write throttle missing");
  a_hot_cause: assert property (|(o_row_hot & ~$past(o_row_hot)) |-> $past(i_xfer.valid))
    else $error("row hot without transfer");
endmodule
bind dtt_throttle dtt_throttle_monitor #(.ROWS(ROWS)) i_mon (.i_clk(i_clk), .i_nrst(i_nrst),
  .i_xfer(i_xfer), .i_cfg(i_cfg), .i_over_temp_in_n(i_over_temp_in_n),
  .o_rd_throttle(o_rd_throttle), .o_wr_throttle(o_wr_throttle), .o_ot_irq(o_ot_irq),
  .o_hw_active(o_hw_active), .o_row_hot(o_row_hot));

/* File: tb/tb_dtt_throttle.sv */
// Testbench for the thermal throttle block.
// Assumes inputs change at falling edges only.
`timescale 1ns/1ps
module tb_dtt_throttle;
  logic i_clk = 0;
  logic i_nrst = 0;
  logic hot = 0;
  dtt_pkg::dtt_xfer_t i_xfer = '0;
  dtt_pkg::dtt_cfg_t i_cfg = '0;
  wire logic i_over_temp_in_n;
  logic o_rd_throttle, o_wr_throttle, o_ot_irq, o_hw_active;
  logic [7:0] o_row_hot;
  int n_fail = 0;
  int tests_run = 0;
  dtt_sensor_model i_dtt_sensor_model (.i_hot(hot), .o_alert_n(i_over_temp_in_n));
  dtt_throttle i_dtt_throttle (.i_clk(i_clk), .i_nrst(i_nrst), .i_xfer(i_xfer),
    .i_cfg(i_cfg), .i_over_temp_in_n(i_over_temp_in_n), .o_rd_throttle(o_rd_throttle),
    .o_wr_throttle(o_wr_throttle), .o_ot_irq(o_ot_irq), .o_hw_active(o_hw_active),
    .o_row_hot(o_row_hot));
  initial forever #2 i_clk = ~i_clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [2:0] row, input dtt_pkg::dtt_cyc_t c);
    @(negedge i_clk);
    i_xfer = {1'b1, row, c};
    @(negedge i_clk);
    i_xfer = '0;
    @(negedge i_clk);
  endtask
  // Sums sit at the threshold, then one hit tips each row
  task automatic t_weights;
    repeat (5) send(3'h1, dtt_pkg::DTT_HIT);
    send(3'h3, dtt_pkg::DTT_MISS);
    send(3'h3, dtt_pkg::DTT_EMPTY);
    chk({o_hw_active, o_row_hot[6:0]}, 8'h00);
    send(3'h3, dtt_pkg::DTT_HIT);
    chk(o_row_hot, 8'h08);
    chk({7'h0, o_hw_active}, 8'h01);
    chk({6'h0, o_wr_throttle, o_rd_throttle}, 8'h03);
    send(3'h1, dtt_pkg::DTT_HIT);
    chk(o_row_hot, 8'h0a);
  endtask
  // Into the held window (rows cleared, still throttled), then past it
  task automatic t_expire;
    repeat (1100) @(negedge i_clk);
    chk({o_hw_active, o_wr_throttle, o_row_hot[5:0]}, 8'hc0);
    repeat (1000) @(negedge i_clk);
    chk({o_hw_active, o_wr_throttle, o_row_hot[5:0]}, 8'h00);
  endtask
  task automatic t_sensor(input logic en);
    i_cfg.ot_irq_en = en;
    @(negedge i_clk);
    hot = 1;
    repeat (4) @(negedge i_clk);
    chk({5'h0, o_wr_throttle, o_rd_throttle, o_ot_irq}, {6'h0, 1'b1, en});
    hot = 0;
    repeat (4) @(negedge i_clk);
    chk({6'h0, o_rd_throttle, o_ot_irq}, 8'h00);
  endtask
  // Duty 2 blocks two slots of three; read throttle off by config
  task automatic t_duty;
    logic [7:0] blocked;
    blocked = 8'h00;
    i_cfg.duty = 4'h2;
    hot = 1;
    repeat (4) @(negedge i_clk);
    repeat (3) begin
      @(negedge i_clk);
      blocked = blocked + {7'h0, o_rd_throttle};
    end
    chk(blocked, 8'h02);
    i_cfg.ot_rd_thr_en = 1'b0;
    repeat (2) @(negedge i_clk);
    chk({7'h0, o_rd_throttle}, 8'h00);
    hot = 0;
    repeat (4) @(negedge i_clk);
    i_cfg.ot_rd_thr_en = 1'b1;
    i_cfg.duty = 4'h0;
  endtask
  // Mid-run reset while the sensor holds the pin low
  task automatic t_reset;
    hot = 1;
    repeat (4) @(negedge i_clk);
    chk({7'h0, o_rd_throttle}, 8'h01);
    i_nrst = 0;
    @(negedge i_clk);
    chk({o_hw_active, o_wr_throttle, o_rd_throttle, o_ot_irq, o_row_hot[3:0]}, 8'h00);
    i_nrst = 1;
    repeat (2) @(negedge i_clk);
    chk({7'h0, o_rd_throttle}, 8'h00);
    repeat (2) @(negedge i_clk);
    chk({7'h0, o_rd_throttle}, 8'h01);
    hot = 0;
    repeat (4) @(negedge i_clk);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #40000;
    n_fail++;
    wrap_up;
  end
  initial begin
    i_cfg.threshold = 24'h000005;
    i_cfg.window = 20'h003ff;
    i_cfg.w_hit = 4'h1;
    i_cfg.w_empty = 4'h2;
    i_cfg.w_miss = 4'h3;
    i_cfg.ot_rd_thr_en = 1'b1;
    repeat (2) @(negedge i_clk);
    i_nrst = 1;
    t_weights;
    t_expire;
    t_sensor(1'b1);
    t_sensor(1'b0);
    t_duty;
    t_reset;
    wrap_up;
  end
endmodule
